// ### hdl/task_file_address_decoder.sv
/*
  Task file address decoder top: synchronises host pins, decodes each
  strobe cycle through the selected map and drives slot, strobes and data
  toward the task file register store.
  Assumes the map select comes from configuration logic on i_clk and the
  register store answers i_tf_rd_data combinationally from slot and lane.
*/
`default_nettype none

// Overview of operation
// [RL1] Map select 0..3 picks memory, contiguous, primary or secondary I/O decode.
// [RL2] Map 0 decodes memory strobes with register select high; A10 low uses A3-A0.
// [RL3] Offset 8 and memory window with A0 low reach even data byte.
// [RL4] Offset 9 and window with A0 high reach odd byte; offset D duplicates error/feature.
// [RL5] Map 1 decodes I/O strobes with register select low, offsets from A3-A0.
// [RL6] Map 2 answers at base 1F and alternate registers at 3F, low 6 and 7.
// [RL7] Map 3 answers at base 17 and alternate registers at 37, low 6 and 7.
// [RL8] Read or write picks register at shared offsets; drive address write is dropped.
// [RL9] First eight slots run data through status/command from offset zero.
// [RL10] Data slot is sixteen bits and takes word or byte accesses.
// [RL11] Unmatched accesses leave data bus undriven and writes discarded.
module task_file_address_decoder (
  input  wire logic                             i_clk,        // System clock
  input  wire logic                             i_resetn,     // Async reset, low
  input  wire tf_decode_pkg::map_sel_t          i_map_sel,    // Map select field
  input  wire logic                             i_reg_n,      // Attribute select pin
  input  wire logic                             i_oe_n,       // Memory read strobe
  input  wire logic                             i_we_n,       // Memory write strobe
  input  wire logic                             i_iord_n,     // I/O read strobe
  input  wire logic                             i_iowr_n,     // I/O write strobe
  input  wire logic                             i_word_n,     // Word access, low
  input  wire logic [tf_decode_pkg::ADDR_W-1:0] i_addr,       // Address pins
  input  wire logic [tf_decode_pkg::DATA_W-1:0] i_data,       // Data pins in
  input  wire logic [tf_decode_pkg::DATA_W-1:0] i_tf_rd_data, // Store read data
  output logic      [tf_decode_pkg::DATA_W-1:0] o_data,       // Data pins out
  output logic                                  o_data_oe,    // Data pin drive
  output tf_decode_pkg::tf_slot_t               o_tf_slot,    // Latched slot
  output tf_decode_pkg::lane_t                  o_tf_lane,    // Latched lane
  output logic                                  o_tf_rd,      // Read start pulse
  output logic                                  o_tf_wr,      // Write commit pulse
  output logic      [tf_decode_pkg::DATA_W-1:0] o_tf_wdata    // Write data
);
  import tf_decode_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} state_t;

  pins_t               raw;
  logic [PINS_W-1:0]   s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, flt_q, flt_d;
  logic [PINS_W-1:0]   agree;
  pins_t               pin;
  logic                rd_act;
  logic                wr_act;
  state_t              state_q, state_d;
  tf_slot_t            slot_q, slot_d;
  lane_t               lane_q, lane_d;
  logic                rd_q, rd_d;
  logic                wr_q, wr_d;
  logic                oe_q, oe_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic [DATA_W-1:0]   wdata_q, wdata_d;

  tf_dec_if dec_if ();

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, three stages plus agreement filter
  assign raw = '{i_reg_n, i_oe_n, i_we_n, i_iord_n, i_iowr_n, i_word_n,
                 i_addr, i_data};

  always_comb begin
    s1_d  = raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    agree = ~(s2_q ^ s3_q);
    flt_d = (s3_q & agree) | (flt_q & ~agree);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q  <= PINS_IDLE;
      s2_q  <= PINS_IDLE;
      s3_q  <= PINS_IDLE;
      flt_q <= PINS_IDLE;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      flt_q <= flt_d;
    end
  end

  assign pin = pins_t'(flt_q);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe choice by map: memory strobes only in map 0
  always_comb begin
    if (i_map_sel == MAP_MEM) begin  // see [RL2] [RL5]
      rd_act = !pin.oe_n;
      wr_act = !pin.we_n;
    end else begin
      rd_act = !pin.iord_n;
      wr_act = !pin.iowr_n;
    end
  end

  // Decoder request
  assign dec_if.map_sel  = i_map_sel;
  assign dec_if.reg_n    = pin.reg_n;
  assign dec_if.word_n   = pin.word_n;
  assign dec_if.is_write = wr_act;
  assign dec_if.addr     = pin.addr;

  tf_map_decoder u_dec (
    .d (dec_if.dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer next state
  always_comb begin
    state_d = state_q;
    slot_d  = slot_q;
    lane_d  = lane_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    oe_d    = 1'b0;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    case (state_q)
      ST_IDLE: begin
        if (dec_if.hit && rd_act && !wr_act) begin
          state_d = ST_READ;
          slot_d  = dec_if.slot;
          lane_d  = dec_if.lane;
          rd_d    = 1'b1;
        end else if (dec_if.hit && wr_act && !rd_act) begin
          state_d = ST_WRITE;  // see [RL8]
          slot_d  = dec_if.slot;
          lane_d  = dec_if.lane;
          wdata_d = pin.data;
        end
      end
      ST_READ: begin
        rdata_d = i_tf_rd_data;  // see [RL10]
        if (rd_act) begin
          oe_d = 1'b1;
        end else begin
          state_d = ST_IDLE;  // see [RL11]
        end
      end
      ST_WRITE: begin
        if (wr_act) begin
          wdata_d = pin.data;
        end else begin
          state_d = ST_IDLE;
          wr_d    = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Access sequencer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      slot_q  <= SLOT_NONE;
      lane_q  <= LANE_EVEN;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      oe_q    <= 1'b0;
      rdata_q <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      slot_q  <= slot_d;
      lane_q  <= lane_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      oe_q    <= oe_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
    end
  end

  // Outputs
  assign o_data     = rdata_q;
  assign o_data_oe  = oe_q;
  assign o_tf_slot  = slot_q;
  assign o_tf_lane  = lane_q;
  assign o_tf_rd    = rd_q;
  assign o_tf_wr    = wr_q;
  assign o_tf_wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  map_mem_idle_a: assert property (  // see [RL1]
    (state_q == ST_IDLE && i_map_sel == MAP_MEM && pin.oe_n && pin.we_n)
    |=> state_q == ST_IDLE)
    else $error("memory map started without memory strobe");

  mem_reg_high_a: assert property (  // see [RL2]
    (dec_if.hit && i_map_sel == MAP_MEM) |-> pin.reg_n)
    else $error("memory map hit with register select low");

  even_window_a: assert property (  // see [RL3]
    (i_map_sel == MAP_MEM && pin.reg_n && pin.addr[A_MEM_WIN] && !pin.addr[A_ODD_BIT])
    |-> (dec_if.slot == SLOT_DATA && dec_if.lane == LANE_EVEN))
    else $error("memory window even byte misdecoded");

  odd_dup_a: assert property (  // see [RL4]
    (dec_if.hit && !pin.addr[A_MEM_WIN] && pin.addr[A_OFF_MSB:A_ODD_BIT] == OFF_DUP_ERR
     && i_map_sel inside {MAP_MEM, MAP_IO_CONTIG})
    |-> dec_if.slot == SLOT_ERR_FEAT)
    else $error("duplicate error offset misdecoded");

  io_reg_low_a: assert property (  // see [RL5]
    (dec_if.hit && i_map_sel != MAP_MEM) |-> !pin.reg_n)
    else $error("I/O map hit with register select high");

  primary_base_a: assert property (  // see [RL6]
    (dec_if.hit && i_map_sel == MAP_IO_PRIMARY)
    |-> (pin.addr[A_HI_MSB:A_HI_LSB] == PRI_TF_BASE
         || pin.addr[A_HI_MSB:A_HI_LSB] == PRI_ALT_BASE))
    else $error("primary map hit outside its bases");

  secondary_base_a: assert property (  // see [RL7]
    (dec_if.hit && i_map_sel == MAP_IO_SECONDARY)
    |-> (pin.addr[A_HI_MSB:A_HI_LSB] == SEC_TF_BASE
         || pin.addr[A_HI_MSB:A_HI_LSB] == SEC_ALT_BASE))
    else $error("secondary map hit outside its bases");

  drive_addr_ro_a: assert property (  // see [RL8]
    (state_q == ST_WRITE) |-> slot_q != SLOT_DRV_ADDR)
    else $error("write accepted at drive address");

  slot_order_a: assert property (  // see [RL9]
    (dec_if.hit && i_map_sel == MAP_IO_CONTIG && !pin.addr[A_SEL_BIT])
    |-> dec_if.slot == tf_slot_t'({1'b0, pin.addr[A_SEL_BIT-1:A_ODD_BIT]}))
    else $error("task file slot order wrong");

  read_data_a: assert property (  // see [RL10]
    (state_q == ST_READ && rd_act) |=> (o_data_oe && o_data == $past(i_tf_rd_data)))
    else $error("read data not presented");

  idle_undriven_a: assert property (  // see [RL11]
    (state_q == ST_IDLE) |=> !o_data_oe)
    else $error("data bus driven outside a matched read");

  write_commit_a: assert property (  // see [RL11]
    o_tf_wr |-> ($past(state_q) == ST_WRITE && !$past(wr_act) && slot_q != SLOT_NONE))
    else $error("write pulse without a matched write");

  read_seen_c: cover property (o_tf_rd ##1 o_data_oe [*2] ##1 !o_data_oe);
  write_seen_c: cover property (state_q == ST_WRITE ##[1:20] o_tf_wr);
  window_read_c: cover property (rd_q && i_map_sel == MAP_MEM && lane_q == LANE_ODD);
  alt_write_c: cover property (
    wr_q && i_map_sel == MAP_IO_PRIMARY && slot_q == SLOT_ALT_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Further decode and sequencing checks
  odd_window_a: assert property (  // see [RL4]
    (i_map_sel == MAP_MEM && pin.reg_n && pin.addr[A_MEM_WIN] && pin.addr[A_ODD_BIT])
    |-> (dec_if.slot == SLOT_DATA && dec_if.lane == LANE_ODD))
    else $error("memory window odd byte misdecoded");

  dup_even_a: assert property (  // see [RL3]
    (dec_if.hit && !pin.addr[A_MEM_WIN] && i_map_sel inside {MAP_MEM, MAP_IO_CONTIG}
     && pin.addr[A_OFF_MSB:A_ODD_BIT] == OFF_DUP_EVEN)
    |-> (dec_if.slot == SLOT_DATA && dec_if.lane == LANE_EVEN))
    else $error("duplicate even data offset misdecoded");

  gap_offsets_a: assert property (  // see [RL11]
    (i_map_sel inside {MAP_MEM, MAP_IO_CONTIG} && !pin.addr[A_MEM_WIN]
     && pin.addr[A_OFF_MSB:A_ODD_BIT] > OFF_DUP_ODD
     && pin.addr[A_OFF_MSB:A_ODD_BIT] < OFF_DUP_ERR)
    |-> !dec_if.hit)
    else $error("unused task file offset decoded");

  fixed_a3_low_a: assert property (  // see [RL6] [RL7]
    (dec_if.hit && i_map_sel inside {MAP_IO_PRIMARY, MAP_IO_SECONDARY})
    |-> !pin.addr[A_SEL_BIT])
    else $error("fixed map hit with A3 high");

  word_lane_a: assert property (  // see [RL10]
    (dec_if.hit && dec_if.lane == LANE_WORD)
    |-> (!pin.word_n && pin.addr[A_OFF_MSB:A_ODD_BIT] == OFF_DATA))
    else $error("word lane outside the data offset");

  both_strobes_a: assert property (  // see [RL8]
    (state_q == ST_IDLE && rd_act && wr_act) |=> state_q == ST_IDLE)
    else $error("access started with both strobes low");

  io_map_idle_a: assert property (  // see [RL5]
    (state_q == ST_IDLE && i_map_sel != MAP_MEM && pin.iord_n && pin.iowr_n)
    |=> state_q == ST_IDLE)
    else $error("I/O map started without I/O strobe");

  write_data_a: assert property (  // see [RL10]
    (state_q == ST_WRITE && wr_act) |=> o_tf_wdata == $past(pin.data))
    else $error("write data not captured");

  read_pulse_a: assert property (  // see [RL8]
    o_tf_rd |-> (state_q == ST_READ && !$past(o_tf_rd)))
    else $error("read pulse outside the first read cycle");

endmodule

`default_nettype wire

// ### hdl/tf_decode_pkg.sv
/*
  Constants and types for the task file address decoder: address fields,
  map selection, decoded slots and byte lanes.
  Assumes the host pins follow the card bus naming of strobes and address.
*/
`default_nettype none

package tf_decode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int OFF_W  = 4;
  localparam int HI_W   = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Address bit positions
  localparam int A_ODD_BIT = 0;
  localparam int A_SEL_BIT = 3;
  localparam int A_OFF_MSB = 3;
  localparam int A_HI_LSB  = 4;
  localparam int A_HI_MSB  = 9;
  localparam int A_MEM_WIN = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Task file offsets
  localparam logic [OFF_W-1:0] OFF_DATA     = 4'h0;
  localparam logic [OFF_W-1:0] OFF_ERR_FEAT = 4'h1;
  localparam logic [OFF_W-1:0] OFF_SEC_CNT  = 4'h2;
  localparam logic [OFF_W-1:0] OFF_SEC_NUM  = 4'h3;
  localparam logic [OFF_W-1:0] OFF_CYL_LO   = 4'h4;
  localparam logic [OFF_W-1:0] OFF_CYL_HI   = 4'h5;
  localparam logic [OFF_W-1:0] OFF_DRV_HEAD = 4'h6;
  localparam logic [OFF_W-1:0] OFF_STAT_CMD = 4'h7;
  localparam logic [OFF_W-1:0] OFF_DUP_EVEN = 4'h8;
  localparam logic [OFF_W-1:0] OFF_DUP_ODD  = 4'h9;
  localparam logic [OFF_W-1:0] OFF_DUP_ERR  = 4'hD;
  localparam logic [OFF_W-1:0] OFF_ALT      = 4'hE;
  localparam logic [OFF_W-1:0] OFF_DRV_ADDR = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed I/O map bases and low addresses
  localparam logic [HI_W-1:0]  PRI_TF_BASE  = 6'h1F;
  localparam logic [HI_W-1:0]  PRI_ALT_BASE = 6'h3F;
  localparam logic [HI_W-1:0]  SEC_TF_BASE  = 6'h17;
  localparam logic [HI_W-1:0]  SEC_ALT_BASE = 6'h37;
  localparam logic [OFF_W-1:0] FIX_ALT_ADDR = 4'h6;
  localparam logic [OFF_W-1:0] FIX_DRV_ADDR = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MAP_MEM, MAP_IO_CONTIG, MAP_IO_PRIMARY, MAP_IO_SECONDARY
  } map_sel_t;

  typedef enum logic [3:0] {
    SLOT_DATA, SLOT_ERR_FEAT, SLOT_SEC_CNT, SLOT_SEC_NUM, SLOT_CYL_LO,
    SLOT_CYL_HI, SLOT_DRV_HEAD, SLOT_STAT_CMD, SLOT_ALT_CTRL, SLOT_DRV_ADDR,
    SLOT_NONE
  } tf_slot_t;

  typedef enum logic [1:0] {LANE_EVEN, LANE_ODD, LANE_WORD} lane_t;

  typedef struct packed {
    logic              reg_n;
    logic              oe_n;
    logic              we_n;
    logic              iord_n;
    logic              iowr_n;
    logic              word_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pins_t;

  localparam int    PINS_W    = $bits(pins_t);
  localparam pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0, '0};

endpackage

`default_nettype wire

// ### hdl/tf_dec_if.sv
/*
  Carrier between the top module and the map decoder.
  Assumes filtered pin values on the request side, same clock domain.
*/
`default_nettype none

interface tf_dec_if;
  import tf_decode_pkg::*;

  map_sel_t          map_sel;
  logic              reg_n;
  logic              word_n;
  logic              is_write;
  logic [ADDR_W-1:0] addr;
  logic              hit;
  tf_slot_t          slot;
  lane_t             lane;

  // Decoder side
  modport dec (input map_sel, reg_n, word_n, is_write, addr,
               output hit, slot, lane);
  // Requesting side
  modport user (output map_sel, reg_n, word_n, is_write, addr,
                input hit, slot, lane);
endinterface

`default_nettype wire

// ### hdl/tf_map_decoder.sv
/*
  Combinational map decoder: turns map select, register select and address
  into a task file slot and byte lane.
  Assumes the caller has already chosen memory or I/O strobes by map.
*/
`default_nettype none

module tf_map_decoder (
  tf_dec_if.dec d  // Decode request in, slot out
);
  import tf_decode_pkg::*;

  logic             cand;
  logic             win;
  logic [OFF_W-1:0] off;
  logic [OFF_W:0]   fix;

  // Fixed map match: valid flag over offset
  function automatic logic [OFF_W:0] fixed_io(input logic [HI_W-1:0]   tf_base,
                                               input logic [HI_W-1:0]   alt_base,
                                               input logic [ADDR_W-1:0] a);
    logic [OFF_W:0] r;
    r = '0;
    if (a[A_HI_MSB:A_HI_LSB] == tf_base && !a[A_SEL_BIT]) begin
      r = {1'b1, 1'b0, a[A_SEL_BIT-1:A_ODD_BIT]};
    end else if (a[A_HI_MSB:A_HI_LSB] == alt_base) begin
      if (a[A_OFF_MSB:A_ODD_BIT] == FIX_ALT_ADDR) begin
        r = {1'b1, OFF_ALT};
      end else if (a[A_OFF_MSB:A_ODD_BIT] == FIX_DRV_ADDR) begin
        r = {1'b1, OFF_DRV_ADDR};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Map to candidate offset
  always_comb begin
    cand = 1'b0;
    win  = 1'b0;
    off  = OFF_DATA;
    fix  = '0;
    case (d.map_sel)  // see [RL1]
      MAP_MEM: begin
        if (d.reg_n) begin  // see [RL2]
          if (d.addr[A_MEM_WIN]) begin
            win = 1'b1;  // see [RL3]
          end else begin
            cand = 1'b1;
            off  = d.addr[A_OFF_MSB:A_ODD_BIT];
          end
        end
      end
      MAP_IO_CONTIG: begin
        if (!d.reg_n) begin  // see [RL5]
          cand = 1'b1;
          off  = d.addr[A_OFF_MSB:A_ODD_BIT];
        end
      end
      MAP_IO_PRIMARY: begin
        if (!d.reg_n) begin
          fix = fixed_io(PRI_TF_BASE, PRI_ALT_BASE, d.addr);  // see [RL6]
        end
      end
      MAP_IO_SECONDARY: begin
        if (!d.reg_n) begin
          fix = fixed_io(SEC_TF_BASE, SEC_ALT_BASE, d.addr);  // see [RL7]
        end
      end
      default: begin
      end
    endcase
    if (fix[OFF_W]) begin
      cand = 1'b1;
      off  = fix[OFF_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset to slot and lane
  always_comb begin
    d.slot = SLOT_NONE;
    d.lane = LANE_EVEN;
    if (win) begin
      d.slot = SLOT_DATA;  // see [RL3] [RL4]
      d.lane = d.addr[A_ODD_BIT] ? LANE_ODD : LANE_EVEN;
    end else if (cand) begin
      case (off)  // see [RL9]
        OFF_DATA: begin
          d.slot = SLOT_DATA;
          d.lane = d.word_n ? LANE_EVEN : LANE_WORD;  // see [RL10]
        end
        OFF_ERR_FEAT: d.slot = SLOT_ERR_FEAT;  // see [RL8]
        OFF_SEC_CNT:  d.slot = SLOT_SEC_CNT;
        OFF_SEC_NUM:  d.slot = SLOT_SEC_NUM;
        OFF_CYL_LO:   d.slot = SLOT_CYL_LO;
        OFF_CYL_HI:   d.slot = SLOT_CYL_HI;
        OFF_DRV_HEAD: d.slot = SLOT_DRV_HEAD;
        OFF_STAT_CMD: d.slot = SLOT_STAT_CMD;
        OFF_DUP_EVEN: d.slot = SLOT_DATA;
        OFF_DUP_ODD: begin
          d.slot = SLOT_DATA;
          d.lane = LANE_ODD;  // see [RL4]
        end
        OFF_DUP_ERR:  d.slot = SLOT_ERR_FEAT;  // see [RL4]
        OFF_ALT:      d.slot = SLOT_ALT_CTRL;
        OFF_DRV_ADDR: begin
          if (!d.is_write) begin
            d.slot = SLOT_DRV_ADDR;  // see [RL8]
          end
        end
        default: d.slot = SLOT_NONE;  // see [RL11]
      endcase
    end
  end

  // Any matched slot
  assign d.hit = (d.slot != SLOT_NONE);

endmodule

`default_nettype wire

// ### tb/tf_host_model.sv
/*
  Host adapter model: drives card pins for one memory or I/O cycle at a time.
  Assumes the caller picks strobe kind and register select for each cycle.
*/
`default_nettype none

module tf_host_model (
  input  wire logic        i_clk,    // Bench clock
  output logic             o_reg_n,  // Register select pin
  output logic             o_oe_n,   // Memory read strobe
  output logic             o_we_n,   // Memory write strobe
  output logic             o_iord_n, // I/O read strobe
  output logic             o_iowr_n, // I/O write strobe
  output logic             o_word_n, // Word access, low
  output logic [10:0]      o_addr,   // Address pins
  output logic [15:0]      o_data    // Write data pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins at time zero; register select has a pull-up
  initial begin
    {o_reg_n, o_oe_n, o_we_n, o_iord_n, o_iowr_n, o_word_n} = 6'h3F;
    o_addr = 11'h000;
    o_data = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One strobe cycle: address first, strobe held, then release
  task automatic access(input logic is_mem, rn, wr, wn, input logic [10:0] a,
                        input logic [15:0] d);
    @(negedge i_clk);
    o_reg_n  = rn;
    o_word_n = wn;
    o_addr   = a;
    o_data   = d;
    @(negedge i_clk);
    if (is_mem) begin
      if (wr) o_we_n = 1'b0;
      else o_oe_n = 1'b0;
    end else begin
      if (wr) o_iowr_n = 1'b0;
      else o_iord_n = 1'b0;
    end
    repeat (8) @(negedge i_clk);
    // Released lines stop showing the old value
    {o_oe_n, o_we_n, o_iord_n, o_iowr_n} = 4'hF;
    o_reg_n = 1'b1;
    o_addr  = ~a;
    o_data  = ~d;
  endtask
endmodule

`default_nettype wire

// ### tb/task_file_address_decoder_tb.sv
/*
  Self-checking bench for the task file address decoder: sweeps every map
  and offset, then random cycles with wrong strobes and register select.
  Assumes a combinational register store answering from slot and lane.
*/
`default_nettype none

module task_file_address_decoder_tb;
  import tf_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk = 1'b0;
  logic        i_resetn;
  map_sel_t    i_map_sel;
  logic        reg_n, oe_n, we_n, iord_n, iowr_n, word_n;
  logic [10:0] addr;
  logic [15:0] hdata, o_data, o_tf_wdata, rd_data, cap_data, cap_wdata;
  logic        o_data_oe, o_tf_rd, o_tf_wr, oe_seen;
  tf_slot_t    o_tf_slot;
  lane_t       o_tf_lane;
  int          fail_count = 0, n_compared = 0, rd_cnt, wr_cnt;
  int          seed = 32'h93285FB8;
  logic [31:0] r;

  always #4 i_clk = ~i_clk;

  // Store answer pattern, unique per slot and lane
  function automatic logic [15:0] store_val(input tf_slot_t s, input lane_t l);
    return {4'hA, s, 6'h15, l};
  endfunction
  assign rd_data = store_val(o_tf_slot, o_tf_lane);

  tf_host_model host_u (.i_clk(i_clk), .o_reg_n(reg_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_iord_n(iord_n), .o_iowr_n(iowr_n), .o_word_n(word_n), .o_addr(addr),
    .o_data(hdata));

  task_file_address_decoder dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_map_sel(i_map_sel), .i_reg_n(reg_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_iord_n(iord_n), .i_iowr_n(iowr_n), .i_word_n(word_n), .i_addr(addr),
    .i_data(hdata), .i_tf_rd_data(rd_data), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_tf_slot(o_tf_slot), .o_tf_lane(o_tf_lane), .o_tf_rd(o_tf_rd),
    .o_tf_wr(o_tf_wr), .o_tf_wdata(o_tf_wdata));

  ////////////////////////////////////////////////////////////////////////////
  // Expected slot from map, strobe kind, select, direction and address
  function automatic tf_slot_t exp_slot(input map_sel_t m, input logic is_mem, rn, wr,
                                        input logic [10:0] a);
    logic [3:0] off;
    logic [5:0] tb, ab;
    off = a[3:0];
    tb  = (m == MAP_IO_PRIMARY) ? 6'h1F : 6'h17;
    ab  = (m == MAP_IO_PRIMARY) ? 6'h3F : 6'h37;
    if (is_mem != (m == MAP_MEM) || rn != (m == MAP_MEM)) return SLOT_NONE;
    if (m == MAP_MEM && a[10]) return SLOT_DATA;
    if (m == MAP_IO_PRIMARY || m == MAP_IO_SECONDARY) begin
      if (a[9:4] == ab && (off == 4'h6 || off == 4'h7)) off = off | 4'h8;
      else if (a[9:4] != tb || a[3]) return SLOT_NONE;
    end
    case (off)
      4'h0, 4'h8, 4'h9: return SLOT_DATA;
      4'h1, 4'hD: return SLOT_ERR_FEAT;
      4'hE: return SLOT_ALT_CTRL;
      4'hF: return wr ? SLOT_NONE : SLOT_DRV_ADDR;
      4'hA, 4'hB, 4'hC: return SLOT_NONE;
      default: return tf_slot_t'(off);
    endcase
  endfunction

  // Expected byte lane of a decoded access
  function automatic lane_t exp_lane(input tf_slot_t s, input logic [10:0] a,
                                     input logic wn, mem_win);
    if (s != SLOT_DATA) return LANE_EVEN;
    if (mem_win || a[3]) return a[0] ? LANE_ODD : LANE_EVEN;
    return wn ? LANE_EVEN : LANE_WORD;
  endfunction

  // Pulse and data capture, sampled where outputs are settled
  always @(negedge i_clk) begin
    if (o_tf_rd === 1'b1) rd_cnt++;
    if (o_tf_wr === 1'b1) begin
      wr_cnt++;
      cap_wdata = o_tf_wdata;
    end
    if (o_data_oe === 1'b1) begin
      oe_seen  = 1'b1;
      cap_data = o_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One host cycle and its checks
  task automatic run(input map_sel_t m, input logic is_mem, rn, wr, wn,
                     input logic [10:0] a, input logic [15:0] d);
    tf_slot_t es, prev;
    lane_t    el;
    es = exp_slot(m, is_mem, rn, wr, a);
    el = exp_lane(es, a, wn, m == MAP_MEM && a[10]);
    @(negedge i_clk);
    i_map_sel = m;
    prev      = o_tf_slot;
    @(posedge i_clk);
    rd_cnt  = 0;
    wr_cnt  = 0;
    oe_seen = 1'b0;
    host_u.access(is_mem, rn, wr, wn, a, d);
    // Release crosses three sync stages and filter, then commit
    repeat (8) @(negedge i_clk);
    if (es == SLOT_NONE) begin
      check(16'(o_tf_slot), 16'(prev));
      check(16'({rd_cnt[3:0], wr_cnt[3:0], 7'h0, oe_seen}), 16'h0);
    end else begin
      check(16'(o_tf_slot), 16'(es));
      check(16'(o_tf_lane), 16'(el));
      check(16'(rd_cnt), 16'(!wr));
      check(16'(wr_cnt), 16'(wr));
      check(16'(oe_seen), 16'(!wr));
      check(16'(o_data_oe), 16'h0);
      if (wr) check(cap_wdata, d);
      else check(cap_data, store_val(es, el));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, full sweep, random cycles
  initial begin
    logic [5:0] hi;
    logic       is_mem, rn;
    i_resetn  = 1'b0;
    i_map_sel = MAP_MEM;
    repeat (5) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_clk);
    check(16'(o_tf_slot), 16'(SLOT_NONE));
    for (int mi = 0; mi < 4; mi++) begin
      for (int off = 0; off < 16; off++) begin
        for (int k = 0; k < 4; k++) begin
          r  = $random(seed);
          hi = (mi == 2) ? (k[1] ? 6'h3F : 6'h1F) : (k[1] ? 6'h37 : 6'h17);
          if (mi < 2 && k[1]) continue;
          run(map_sel_t'(mi[1:0]), mi == 0, mi == 0, k[0], r[7],
              (mi < 2) ? {mi[0] & r[8], r[14:9], off[3:0]} : {r[8], hi, off[3:0]},
              r[31:16]);
        end
      end
    end
    // Random cycles: memory window, wrong select, wrong strobe, wrong base
    for (int i = 0; i < 80; i++) begin
      r      = $random(seed);
      is_mem = (r[1:0] == 2'h0) ^ (r[4:3] == 2'h0);
      rn     = (r[1:0] == 2'h0) ^ (r[6:5] == 2'h0);
      hi     = r[7] ? {r[8], 1'b1, r[9], 3'b111} : r[13:8];
      run(map_sel_t'(r[1:0]), is_mem, rn, r[2], r[14], {r[15], hi, r[19:16]},
          r[31:16]);
    end
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
